// [core/sram_port_pkg.sv]
package sram_port_pkg;

	localparam int ADDR_W = 18;
	localparam int DATA_W = 18;
	localparam int BEATS_MAX = 4;

	// memory clock derived from the system clock
	localparam int SYS_CLK_PERIOD_PS = 8000;
	localparam int MEM_CLK_PERIOD_NS = 160;
	localparam int QUARTER_CYCLES =
		(MEM_CLK_PERIOD_NS * 1000) / (4 * SYS_CLK_PERIOD_PS);
	localparam int SUB_W = 3;
	localparam logic [SUB_W-1:0] SUB_FIRST = 3'h0;
	localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(QUARTER_CYCLES - 1);
	localparam logic [SUB_W-1:0] SUB_PRE_LAST = SUB_W'(QUARTER_CYCLES - 2);

	// quarters of one memory clock period
	localparam logic [1:0] QTR_WCLK_RISE = 2'h0;
	localparam logic [1:0] QTR_K_RISE = 2'h1;
	localparam logic [1:0] QTR_WCLK_FALL = 2'h2;
	localparam logic [1:0] QTR_K_FALL = 2'h3;

	// clock pair values {positive, negative}
	localparam logic [1:0] CLK_PAIR_HIGH = 2'h2;
	localparam logic [1:0] CLK_PAIR_LOW = 2'h1;

	localparam logic [2:0] BURST2_BEATS = 3'h2;
	localparam logic [2:0] BURST4_BEATS = 3'h4;
	localparam logic [2:0] BEATS_NONE = 3'h0;
	localparam logic [2:0] BEAT_ONE = 3'h1;

	// echo edges between read address launch and first read beat
	localparam int READ_LAT_EDGES = 2;
	// sample delay after an echo edge, mid of the half period
	localparam logic [SUB_W-1:0] SAMPLE_DELAY = SUB_W'(QUARTER_CYCLES);

	typedef enum logic {SLOT_READ, SLOT_WRITE} slot_type;

	typedef struct packed {
		logic rd_req;
		logic wr_req;
		logic [ADDR_W-1:0] rd_addr;
		logic [ADDR_W-1:0] wr_addr;
		logic [BEATS_MAX-1:0][DATA_W-1:0] wr_data;
	} user_req_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic rd_sel_n;
		logic wr_sel_n;
	} mem_cmd_type;

	typedef struct packed {
		logic valid;
		logic [BEATS_MAX-1:0][DATA_W-1:0] data;
	} rd_resp_type;

endpackage : sram_port_pkg

// [core/ddr_out_reg.sv]
`timescale 1ns/1ps
`default_nettype none

// output register launched on either edge of the write clock or of the main clock
module ddr_out_reg #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic rise_en,
	input wire logic fall_en,
	input wire logic [W-1:0] d_rise,
	input wire logic [W-1:0] d_fall,
	output var logic [W-1:0] q_reg
);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q_reg <= RESET_VAL;
		end else if (rise_en) begin
			q_reg <= d_rise;
		end else if (fall_en) begin
			q_reg <= d_fall;
		end
	end

endmodule : ddr_out_reg

`default_nettype wire

// [core/quad_rate_sram_port.sv]
// Operation
// RULE1 - separate read and write data ports, one shared address bus
// RULE2 - data buses and main clock pair go through double-rate out registers
// RULE3 - burst-of-two part takes read address on main rise, write on inverse
// RULE4 - burst-of-four part takes both addresses on main clock rise only
// RULE5 - up to four data words move per memory clock cycle
// RULE6 - each negative clock is the exact inverse of its partner
// RULE7 - device drives both clock pairs; memory returns the echo pair
// RULE8 - single-clock mode: main pair times all, read out pair idle
// RULE9 - multi-device bank: drive both read out pair and main pair
// RULE10 - memory launches read words after each rise of timing clock pair
// RULE11 - echo pair is edge-aligned with read data and captures it
// RULE12 - write data from write clock; main clock shifted ninety degrees
// RULE13 - burst-of-two and burst-of-four address sampling both supported
// RULE14 - read and write requests may be issued in the same cycle
`timescale 1ns/1ps
`default_nettype none

module quad_rate_sram_port (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic burst4_mode,
	input wire logic multi_clock_mode,
	input wire sram_port_pkg::user_req_type user_req,
	output var logic req_ready,
	output var sram_port_pkg::rd_resp_type rd_resp,
	output var sram_port_pkg::mem_cmd_type mem_cmd,
	output var logic [sram_port_pkg::DATA_W-1:0] write_data_out,
	output var logic main_in_clock,
	output var logic main_in_clock_inv,
	output var logic read_out_clock,
	output var logic read_out_clock_inv,
	input wire logic [sram_port_pkg::DATA_W-1:0] read_data_in,
	input wire logic echo_clock,
	input wire logic echo_clock_inv
);

	localparam int DW = sram_port_pkg::DATA_W;
	localparam int LAT = sram_port_pkg::READ_LAT_EDGES;
	localparam int WR_LAUNCH_GAP = 2 * sram_port_pkg::QUARTER_CYCLES;

	////////////////////////////////////////////////////////////////////////
	// memory clock phase

	logic [sram_port_pkg::SUB_W-1:0] sub_reg;
	logic [1:0] quarter_reg;
	logic [3:0] enter_q;
	logic at_end;

	assign at_end = sub_reg == sram_port_pkg::SUB_LAST;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sub_reg <= sram_port_pkg::SUB_FIRST;
			quarter_reg <= sram_port_pkg::QTR_WCLK_RISE;
		end else if (at_end) begin
			sub_reg <= sram_port_pkg::SUB_FIRST;
			quarter_reg <= quarter_reg + 2'h1;
		end else begin
			sub_reg <= sub_reg + 3'h1;
		end
	end

	// enter_q[i]: the edge at which quarter i begins
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_enter
			assign enter_q[gi] = at_end && quarter_reg == 2'((gi + 3) % 4);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// request acceptance and slots

	logic ready_reg;
	logic take;
	logic b4_reg;
	logic mc_reg;
	sram_port_pkg::slot_type slot_reg;
	sram_port_pkg::slot_type slot_next;
	sram_port_pkg::user_req_type op_reg;

	assign take = ready_reg;
	assign req_ready = ready_reg;

	// burst-of-four alternates a read slot and a write slot
	assign slot_next = (b4_reg && slot_reg == sram_port_pkg::SLOT_READ) ?
		sram_port_pkg::SLOT_WRITE : sram_port_pkg::SLOT_READ;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= quarter_reg == sram_port_pkg::QTR_K_FALL &&
				sub_reg == sram_port_pkg::SUB_PRE_LAST &&
				(!b4_reg || slot_reg == sram_port_pkg::SLOT_WRITE);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			slot_reg <= sram_port_pkg::SLOT_READ;
		end else if (enter_q[0]) begin
			slot_reg <= slot_next;
		end
	end

	// modes change whenever a request is taken, even while an earlier burst is in flight
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			b4_reg <= 1'b0;
			mc_reg <= 1'b0;
			op_reg <= '0;
		end else if (take) begin
			b4_reg <= burst4_mode; // RULE13
			mc_reg <= multi_clock_mode;
			op_reg <= user_req; // RULE14
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared address bus and selects

	logic rd_launch;
	logic wr_launch;

	assign rd_launch = enter_q[0] && slot_next == sram_port_pkg::SLOT_READ &&
		take && user_req.rd_req;
	assign wr_launch = op_reg.wr_req &&
		((enter_q[2] && !b4_reg) ||
		(enter_q[0] && slot_next == sram_port_pkg::SLOT_WRITE));

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mem_cmd <= '{addr: '0, rd_sel_n: 1'b1, wr_sel_n: 1'b1};
		end else if (enter_q[0] &&
			slot_next == sram_port_pkg::SLOT_WRITE) begin
			mem_cmd.addr <= op_reg.wr_addr; // RULE4
			mem_cmd.rd_sel_n <= 1'b1;
			mem_cmd.wr_sel_n <= !op_reg.wr_req;
		end else if (enter_q[0]) begin
			mem_cmd.addr <= user_req.rd_addr; // RULE3 RULE4
			mem_cmd.rd_sel_n <= !rd_launch;
			mem_cmd.wr_sel_n <= 1'b1;
		end else if (enter_q[2] && !b4_reg) begin
			mem_cmd.addr <= op_reg.wr_addr; // RULE3 RULE1
			mem_cmd.rd_sel_n <= 1'b1;
			mem_cmd.wr_sel_n <= !op_reg.wr_req;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write data beats, one per write clock edge

	logic [sram_port_pkg::BEATS_MAX-1:0][DW-1:0] wq_reg;
	logic [2:0] wleft_reg;
	logic [1:0] wptr_reg;
	logic wclk_edge;
	logic beat_en;
	logic [DW-1:0] beat_word;
	logic [2:0] burst_beats;

	assign burst_beats = b4_reg ? sram_port_pkg::BURST4_BEATS :
		sram_port_pkg::BURST2_BEATS;
	assign wclk_edge = enter_q[0] || enter_q[2];
	assign beat_en = wr_launch ||
		(wclk_edge && wleft_reg != sram_port_pkg::BEATS_NONE);
	assign beat_word = wr_launch ? op_reg.wr_data[0] : wq_reg[wptr_reg];

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wq_reg <= '0;
			wleft_reg <= sram_port_pkg::BEATS_NONE;
			wptr_reg <= 2'h0;
		end else if (wr_launch) begin
			// copy, since the next request may overwrite op_reg mid burst
			wq_reg <= op_reg.wr_data;
			wleft_reg <= burst_beats - 3'h1;
			wptr_reg <= 2'h1;
		end else if (beat_en) begin
			wleft_reg <= wleft_reg - 3'h1; // RULE5
			wptr_reg <= wptr_reg + 2'h1;
		end
	end

	ddr_out_reg #(.W(DW), .RESET_VAL('0)) u_wdata (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.rise_en(beat_en && enter_q[0]), // RULE2 RULE12
		.fall_en(beat_en && enter_q[2]),
		.d_rise(beat_word),
		.d_fall(beat_word),
		.q_reg(write_data_out)
	);

	////////////////////////////////////////////////////////////////////////
	// clock pairs: main pair sits a quarter after the write clock

	logic [1:0] c_rise_val;

	ddr_out_reg #(.W(2), .RESET_VAL(sram_port_pkg::CLK_PAIR_LOW)) u_kpair (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.rise_en(enter_q[1]), // RULE12 RULE2 RULE7
		.fall_en(enter_q[3]),
		.d_rise(sram_port_pkg::CLK_PAIR_HIGH), // RULE6
		.d_fall(sram_port_pkg::CLK_PAIR_LOW),
		.q_reg({main_in_clock, main_in_clock_inv})
	);

	// single-clock mode parks the read out pair low
	assign c_rise_val = mc_reg ? sram_port_pkg::CLK_PAIR_HIGH :
		sram_port_pkg::CLK_PAIR_LOW; // RULE8 RULE9

	ddr_out_reg #(.W(2), .RESET_VAL(sram_port_pkg::CLK_PAIR_LOW)) u_cpair (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.rise_en(enter_q[1]), // RULE9 RULE7
		.fall_en(enter_q[3]),
		.d_rise(c_rise_val), // RULE6
		.d_fall(sram_port_pkg::CLK_PAIR_LOW),
		.q_reg({read_out_clock, read_out_clock_inv})
	);

	////////////////////////////////////////////////////////////////////////
	// read capture on echo clock edges

	logic [1:0] echo_s1_reg;
	logic [1:0] echo_s2_reg;
	logic [1:0] echo_s3_reg;
	logic [DW-1:0] rdq_s1_reg;
	logic [DW-1:0] rdq_s2_reg;
	logic echo_rise;
	logic echo_inv_rise;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			// idle pair level, so release shows no false edge
			echo_s1_reg <= sram_port_pkg::CLK_PAIR_LOW;
			echo_s2_reg <= sram_port_pkg::CLK_PAIR_LOW;
			echo_s3_reg <= sram_port_pkg::CLK_PAIR_LOW;
			rdq_s1_reg <= '0;
			rdq_s2_reg <= '0;
		end else begin
			echo_s1_reg <= {echo_clock, echo_clock_inv};
			echo_s2_reg <= echo_s1_reg;
			echo_s3_reg <= echo_s2_reg;
			rdq_s1_reg <= read_data_in;
			rdq_s2_reg <= rdq_s1_reg;
		end
	end

	assign echo_rise = echo_s2_reg[1] && !echo_s3_reg[1];
	assign echo_inv_rise = echo_s2_reg[0] && !echo_s3_reg[0];

	// data is edge-aligned, so sample mid way to the next edge
	logic [sram_port_pkg::SUB_W-1:0] samp_cnt_reg;
	logic samp_main_reg;
	logic samp_now;

	assign samp_now = samp_cnt_reg == 3'h1;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			samp_cnt_reg <= 3'h0;
			samp_main_reg <= 1'b0;
		end else if (echo_rise || echo_inv_rise) begin
			samp_cnt_reg <= sram_port_pkg::SAMPLE_DELAY; // RULE11
			samp_main_reg <= echo_rise;
		end else if (samp_cnt_reg != 3'h0) begin
			samp_cnt_reg <= samp_cnt_reg - 3'h1;
		end
	end

	// echo runs free; reads are tracked through a latency pipe
	logic pend_reg;
	logic [LAT-1:0] rd_pipe_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pend_reg <= 1'b0;
			rd_pipe_reg <= '0;
		end else if (echo_rise) begin
			pend_reg <= rd_launch; // RULE10
			rd_pipe_reg <= {rd_pipe_reg[LAT-2:0], pend_reg || rd_launch};
		end else if (rd_launch) begin
			pend_reg <= 1'b1;
		end
	end

	logic [2:0] rleft_reg;
	logic [1:0] rptr_reg;
	logic rd_start;

	assign rd_start = samp_now && samp_main_reg && rd_pipe_reg[LAT-1] &&
		rleft_reg == sram_port_pkg::BEATS_NONE;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rleft_reg <= sram_port_pkg::BEATS_NONE;
			rptr_reg <= 2'h0;
			rd_resp <= '0;
		end else begin
			rd_resp.valid <= 1'b0;
			if (rd_start) begin
				rd_resp.data[0] <= rdq_s2_reg; // RULE11
				rleft_reg <= burst_beats - 3'h1;
				rptr_reg <= 2'h1;
			end else if (samp_now &&
				rleft_reg != sram_port_pkg::BEATS_NONE) begin
				rd_resp.data[rptr_reg] <= rdq_s2_reg; // RULE5
				rleft_reg <= rleft_reg - 3'h1;
				rptr_reg <= rptr_reg + 2'h1;
				rd_resp.valid <= rleft_reg == sram_port_pkg::BEAT_ONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_k_inverse;
		@(posedge clk_sys) disable iff (!rst_n)
		main_in_clock_inv == !main_in_clock;
	endproperty
	a_k_inverse: assert property (p_k_inverse) // RULE6
		else $error("main clock pair not complementary");

	property p_c_inverse;
		@(posedge clk_sys) disable iff (!rst_n)
		read_out_clock_inv != read_out_clock;
	endproperty
	a_c_inverse: assert property (p_c_inverse) // RULE6
		else $error("read out clock pair not complementary");

	property p_single_clock_idle;
		@(posedge clk_sys) disable iff (!rst_n)
		(!mc_reg && enter_q[1]) |=> !read_out_clock [*4];
	endproperty
	a_single_clock_idle: assert property (p_single_clock_idle) // RULE8
		else $error("read out clock toggles in single-clock mode");

	property p_multi_clock_follow;
		@(posedge clk_sys) disable iff (!rst_n)
		(mc_reg && enter_q[1]) |=> read_out_clock && main_in_clock;
	endproperty
	a_multi_clock_follow: assert property (p_multi_clock_follow) // RULE9
		else $error("read out clock not driven in multi-clock mode");

	property p_k_shifted;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(main_in_clock) |->
			quarter_reg == sram_port_pkg::QTR_K_RISE &&
			sub_reg == sram_port_pkg::SUB_FIRST;
	endproperty
	a_k_shifted: assert property (p_k_shifted) // RULE12
		else $error("main clock rise not a quarter after write clock");

	property p_data_on_wclk;
		@(posedge clk_sys) disable iff (!rst_n)
		$changed(write_data_out) |-> sub_reg == sram_port_pkg::SUB_FIRST &&
			!quarter_reg[0];
	endproperty
	a_data_on_wclk: assert property (p_data_on_wclk) // RULE2
		else $error("write data changed off a write clock edge");

	property p_b2_write_addr;
		@(posedge clk_sys) disable iff (!rst_n)
		(!mem_cmd.wr_sel_n && !b4_reg) |->
			quarter_reg[1] && mem_cmd.rd_sel_n;
	endproperty
	a_b2_write_addr: assert property (p_b2_write_addr) // RULE3
		else $error("burst-of-two write address outside inverse clock half");

	property p_b4_slots;
		@(posedge clk_sys) disable iff (!rst_n)
		(b4_reg && !mem_cmd.wr_sel_n) |-> mem_cmd.rd_sel_n &&
			slot_reg == sram_port_pkg::SLOT_WRITE;
	endproperty
	a_b4_slots: assert property (p_b4_slots) // RULE4 RULE13
		else $error("burst-of-four write address not in its own slot");

	property p_concurrent;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && user_req.rd_req && user_req.wr_req && !burst4_mode) |=>
			!mem_cmd.rd_sel_n ##WR_LAUNCH_GAP !mem_cmd.wr_sel_n;
	endproperty
	a_concurrent: assert property (p_concurrent) // RULE14 RULE1
		else $error("same-cycle read and write not both issued");

endmodule : quad_rate_sram_port

`default_nettype wire

// [test/sram_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

module sram_mem_model (
	input wire logic main_in_clock,
	input wire logic main_in_clock_inv,
	input wire logic read_out_clock,
	input wire sram_port_pkg::mem_cmd_type mem_cmd,
	input wire logic [17:0] write_data_out,
	input wire logic burst4,
	input wire logic use_c,
	input wire logic slow,
	output var logic [17:0] read_data_in,
	output var logic echo_clock,
	output var logic echo_clock_inv
);
	logic [17:0] mem [logic [19:0]];
	logic [17:0] beats [$];
	logic [17:0] rq [$];
	realtime rt [$];
	logic [17:0] wa;
	int w_left = 0;
	int w_idx = 0;
	wire logic tclk = use_c ? read_out_clock : main_in_clock;

	initial begin
		read_data_in = '0;
		echo_clock = 1'b0;
		echo_clock_inv = 1'b1;
	end

	task automatic take_beat();
		if (w_left > 0) begin
			mem[{wa, w_idx[1:0]}] = write_data_out;
			w_idx++;
			w_left--;
		end
	endtask : take_beat

	////////////////////////////////
	always @(posedge main_in_clock) begin
		take_beat();
		if (burst4 && mem_cmd.wr_sel_n === 1'b0) begin
			wa = mem_cmd.addr;
			w_idx = 0;
			w_left = 4;
			take_beat();
		end
		// time stamp keeps the sampling edge from also launching
		if (mem_cmd.rd_sel_n === 1'b0) begin
			rq.push_back(mem_cmd.addr);
			rt.push_back($realtime);
		end
	end

	always @(posedge main_in_clock_inv) begin
		take_beat();
		if (!burst4 && mem_cmd.wr_sel_n === 1'b0) begin
			wa = mem_cmd.addr;
			w_idx = 0;
			w_left = 2;
			take_beat();
		end
	end

	// idle data toggles so a late capture never sees a stale word
	always @(tclk) begin
		logic [17:0] nxt;
		int dly;
		if (tclk === 1'b1) begin
			while (rt.size() > 0 && rt[0] < $realtime) begin
				for (int i = 0; i < (burst4 ? 4 : 2); i++) begin
					nxt = mem.exists({rq[0], 2'(i)}) ? mem[{rq[0], 2'(i)}] : '0;
					beats.push_back(nxt);
				end
				rq.delete(0);
				rt.delete(0);
			end
		end
		nxt = beats.size() > 0 ? beats.pop_front() : ~read_data_in;
		dly = slow ? 20 : 2;
		echo_clock <= #(dly) tclk;
		echo_clock_inv <= #(dly) ~tclk;
		read_data_in <= #(dly) nxt;
	end
endmodule : sram_mem_model

`default_nettype wire

// [test/quad_rate_sram_port_test.sv]
`timescale 1ns/1ps
`default_nettype none

module quad_rate_sram_port_test;
	typedef struct packed {
		logic b4;
		logic mc;
		logic rd;
		logic wr;
		logic [17:0] ra;
		logic [17:0] wa;
		logic [17:0] seed;
		logic [17:0] exp_seed;
	} row_type;
	logic clk_sys, rst_n, burst4_mode, multi_clock_mode, slow, req_ready;
	logic main_in_clock, main_in_clock_inv, echo_clock, echo_clock_inv;
	logic read_out_clock, read_out_clock_inv;
	logic [17:0] write_data_out, read_data_in;
	sram_port_pkg::user_req_type user_req;
	sram_port_pkg::rd_resp_type rd_resp;
	sram_port_pkg::mem_cmd_type mem_cmd;
	logic [17:0] exp_q [$];
	logic exp_b4 [$];
	int n_fail = 0;
	int total_checks = 0;
	int n;
	row_type rows [9] = '{
		'{0, 0, 0, 1, 18'h0, 18'h10, 18'h1000, 18'h0},
		'{0, 0, 1, 1, 18'h10, 18'h20, 18'h2000, 18'h1000},
		'{0, 0, 1, 1, 18'h20, 18'h3FFFF, 18'h3FFF0, 18'h2000},
		'{0, 1, 1, 1, 18'h3FFFF, 18'h0, 18'h2AAAA, 18'h3FFF0},
		'{0, 1, 1, 0, 18'h0, 18'h0, 18'h0, 18'h2AAAA},
		'{1, 0, 0, 1, 18'h0, 18'h100, 18'h15550, 18'h0},
		'{1, 0, 1, 1, 18'h100, 18'h200, 18'h0F0F0, 18'h15550},
		'{1, 1, 1, 1, 18'h200, 18'h300, 18'h33330, 18'h0F0F0},
		'{1, 1, 1, 0, 18'h300, 18'h0, 18'h0, 18'h33330}
	};

	quad_rate_sram_port dut (
		.clk_sys, .rst_n, .burst4_mode, .multi_clock_mode, .user_req,
		.req_ready, .rd_resp, .mem_cmd, .write_data_out, .main_in_clock,
		.main_in_clock_inv, .read_out_clock, .read_out_clock_inv,
		.read_data_in, .echo_clock, .echo_clock_inv
	);
	sram_mem_model mem_model (
		.main_in_clock, .main_in_clock_inv, .read_out_clock, .mem_cmd,
		.write_data_out, .burst4(burst4_mode), .use_c(multi_clock_mode),
		.slow, .read_data_in, .echo_clock, .echo_clock_inv
	);

	////////////////////////////////
	task automatic check(input string nm, input logic [17:0] e,
		input logic [17:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : check

	task automatic check_bit(input string nm, input logic e, input logic g);
		check(nm, 18'(e), 18'(g));
	endtask : check_bit

	task automatic summarize();
		if (n_fail == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	task automatic give_up();
		n_fail++;
		$display("[ERR] wait exp done got timeout");
		summarize();
	endtask : give_up

	task automatic wait_ready(output int cnt);
		cnt = 0;
		do begin
			@(posedge clk_sys);
			cnt++;
			if (cnt > 100) give_up();
		end while (req_ready !== 1'b1);
	endtask : wait_ready

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		check_bit("main_in_clock", 1'b0, main_in_clock);
		check_bit("main_in_clock_inv", 1'b1, main_in_clock_inv);
		check_bit("read_out_clock", 1'b0, read_out_clock);
		check_bit("rd_sel_n", 1'b1, mem_cmd.rd_sel_n);
		check_bit("wr_sel_n", 1'b1, mem_cmd.wr_sel_n);
		check_bit("req_ready", 1'b0, req_ready);
		check_bit("rd_valid", 1'b0, rd_resp.valid);
	endtask : do_reset

	// request held until the edge that takes it
	task automatic issue(input row_type r);
		sram_port_pkg::user_req_type q;
		int cnt;
		q.rd_req = r.rd;
		q.wr_req = r.wr;
		q.rd_addr = r.ra;
		q.wr_addr = r.wa;
		for (int i = 0; i < 4; i++) begin
			q.wr_data[i] = r.seed + 18'(i);
		end
		@(posedge clk_sys);
		burst4_mode <= r.b4;
		multi_clock_mode <= r.mc;
		user_req <= q;
		wait_ready(cnt);
		user_req.rd_req <= 1'b0;
		user_req.wr_req <= 1'b0;
		if (r.rd) begin
			exp_q.push_back(r.exp_seed);
			exp_b4.push_back(r.b4);
		end
	endtask : issue

	// no write completion signal, so in-flight writes get settle time
	task automatic drain();
		int cnt;
		cnt = 0;
		while (exp_q.size() != 0) begin
			@(posedge clk_sys);
			cnt++;
			if (cnt > 200) give_up();
		end
		repeat (60) @(posedge clk_sys);
	endtask : drain

	task automatic walk(input logic mc, input logic sl);
		logic k_hi;
		slow <= sl;
		issue('{1'b0, mc, 1'b1, 1'b1, 18'h3FFFF, 18'h77, 18'h700, 18'h3FFF0});
		for (int k = 1; k <= 21; k++) begin
			#1;
			k_hi = k >= 6 && k <= 15;
			check_bit("main_in_clock", k_hi, main_in_clock);
			check_bit("read_out_clock", mc & k_hi, read_out_clock);
			if (k == 1) begin
				check("addr", 18'h3FFFF, mem_cmd.addr);
				check_bit("rd_sel_n", 1'b0, mem_cmd.rd_sel_n);
			end
			if (k == 11) begin
				check("addr", 18'h77, mem_cmd.addr);
				check_bit("wr_sel_n", 1'b0, mem_cmd.wr_sel_n);
				check("write_data", 18'h700, write_data_out);
			end
			if (k == 21) check("write_data", 18'h701, write_data_out);
			@(posedge clk_sys);
		end
	endtask : walk

	////////////////////////////////
	always @(posedge clk_sys) begin
		logic [17:0] s;
		logic b;
		if (rst_n === 1'b1) begin
			check_bit("k_pair", 1'b1, main_in_clock ^ main_in_clock_inv);
			check_bit("c_pair", 1'b1, read_out_clock ^ read_out_clock_inv);
		end
		if (rd_resp.valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check_bit("rd_valid", 1'b0, 1'b1);
			end else begin
				s = exp_q.pop_front();
				b = exp_b4.pop_front();
				for (int i = 0; i < (b ? 4 : 2); i++) begin
					check("rd_word", s + 18'(i), rd_resp.data[i]);
				end
			end
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	initial begin
		burst4_mode = 1'b0;
		multi_clock_mode = 1'b0;
		slow = 1'b0;
		user_req = '0;
		do_reset();
		wait_ready(n);
		wait_ready(n);
		check("ready_gap", 18'h14, 18'(n));
		foreach (rows[i]) begin
			if (i > 0 && rows[i].b4 != rows[i-1].b4) drain();
			if (i > 0 && rows[i].mc != rows[i-1].mc) drain();
			issue(rows[i]);
		end
		drain();
		walk(1'b0, 1'b0);
		drain();
		walk(1'b1, 1'b1);
		drain();
		do_reset();
		issue(rows[8]);
		drain();
		summarize();
	end
endmodule : quad_rate_sram_port_test

`default_nettype wire
